// ===== pado_pkg.sv
// Purpose: shared constants and carrier types for the converter output port
// Assumes: one 40 MHz system clock; the convert clock arrives as a plain input
// Notes:   one step of the pipeline is one edge (either way) of the convert clock
package pado_pkg;

  localparam int STAGE_COUNT    = 11;  // two-bit pipeline stages
  localparam int STAGE_BITS     = 2;   // partial result per stage
  localparam int WORD_BITS      = 12;  // corrected result width
  localparam int LATENCY_STEPS  = 13;  // half convert cycles, sample edge to word
  localparam int TAG_BITS       = LATENCY_STEPS;
  localparam int CLK_PERIOD_NS  = 25;  // system clock period

  // reset and saturation values
  localparam logic [WORD_BITS-1:0] WORD_RESET = 12'h000;
  localparam logic [WORD_BITS-1:0] WORD_FULL  = 12'hFFF;

  // partial results of all stages, stage 0 in the low slot
  typedef logic [STAGE_COUNT-1:0][STAGE_BITS-1:0] pado_codes_t;

  // one finished sample as it travels through the buffer
  typedef struct packed {
    logic [WORD_BITS-1:0] data;  // bit 11 is the top result bit
  } pado_word_s;

  // output coding chosen by the static format pin
  typedef enum logic {
    PADO_OFFSET_BINARY,
    PADO_TWOS_COMPLEMENT
  } pado_format_e;

endpackage

// ===== pado_word_buffer.sv
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: synchronous active-high reset
// Notes:   the head word always sits in slot 0, so read data comes from a flop
module pado_word_buffer #(
  parameter int WIDTH = 12
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // filling side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // draining side
  output logic                  outValid,
  output logic [WIDTH-1:0]      outData,
  input  wire logic             outReady
);
  import pado_pkg::*;

  logic             valid0_reg, valid0_next;
  logic             valid1_reg, valid1_next;
  logic [WIDTH-1:0] slot0_reg,  slot0_next;
  logic [WIDTH-1:0] slot1_reg,  slot1_next;
  logic             push;
  logic             pop;

  if (WIDTH < 1) begin : g_bad_width
    $error("pado_word_buffer: WIDTH must be at least 1");
  end

  assign inReady  = !valid1_reg;  // full only when both slots hold words
  assign outValid = valid0_reg;
  assign outData  = slot0_reg;
  assign push     = inValid && !valid1_reg;
  assign pop      = valid0_reg && outReady;

  // slot bookkeeping: a pop shifts slot 1 forward, a push fills the first free slot
  always_comb begin
    valid0_next = valid0_reg;
    valid1_next = valid1_reg;
    slot0_next  = slot0_reg;
    slot1_next  = slot1_reg;
    if (pop) begin
      valid0_next = valid1_reg;
      slot0_next  = slot1_reg;
      valid1_next = 1'b0;
    end
    if (push) begin
      if (!valid0_next) begin
        valid0_next = 1'b1;
        slot0_next  = inData;
      end else begin
        valid1_next = 1'b1;
        slot1_next  = inData;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      valid0_reg <= 1'b0;
      valid1_reg <= 1'b0;
      slot0_reg  <= '0;
      slot1_reg  <= '0;
    end else begin
      valid0_reg <= valid0_next;
      valid1_reg <= valid1_next;
      slot0_reg  <= slot0_next;
      slot1_reg  <= slot1_next;
    end
  end

endmodule

// ===== pado_output_port.sv
// Purpose: digital side of a 12-bit pipelined sampling converter
// Assumes: convert clock and static pins are synchronous to clk; no software registers
// Notes:   each convert clock edge is one pipeline step; a word leaves 13 steps after its sample
//          the convert clock must hold each level for two clk cycles or more, or the track and hold phases never rise
//          the first words after the convert clock starts are stale; the capture side drops them
//          the converter cannot be paused, so a receiver stall beyond two words shows as overrun
//          the format pin is read when a word is coded, so a change affects words in flight
//          the disable pin only gates the output enable; words keep moving while it is high
//
// Contract
// - each result leaves as one parallel twelve-bit word.
// - top result bit on the first output, bottom bit on the twelfth.
// - word is valid six and a half convert cycles after its sampling edge.
// - two non-overlapping phases: track while clock high, hold while low.
// - stages step on both convert clock edges, twice the clock rate.
// - eleven stages each deliver a two-bit partial result.
// - partial results are delayed into line, then combined with redundancy correction.
// - format pin low gives offset binary, full scale all ones.
// - format pin high inverts only the top bit for two's complement.
// - disable pin high floats all data outputs; low drives them.
module pado_output_port #(
  parameter int STAGES = pado_pkg::STAGE_COUNT,
  parameter int WIDTH  = pado_pkg::WORD_BITS
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // convert clock from the capture side, sampled on clk
  input  wire logic                 convClk,
  // partial results from the stage comparators, valid on each step
  input  wire pado_pkg::pado_codes_t stageCodes,
  // static control pins
  input  wire logic                 codeFormatSelect,
  input  wire logic                 outDisable,
  // result word, bit 11 is the top bit, bit 0 the bottom bit
  output logic [WIDTH-1:0]          resultBits,
  output logic                      resultOe,
  output logic                      wordValid,
  input  wire logic                 wordReady,
  // track-and-hold phases and status
  output logic                      trackPhase,
  output logic                      holdPhase,
  output logic                      overrun
);
  import pado_pkg::*;

  if (STAGES != STAGE_COUNT || WIDTH != WORD_BITS) begin : g_bad_params
    $error("pado_output_port: STAGES must be 11 and WIDTH 12");
  end

  // the tag line must span the stage steps plus the correction and coding steps
  if (LATENCY_STEPS != STAGE_COUNT + 2) begin : g_bad_latency
    $error("pado_output_port: latency must be two steps beyond the stage count");
  end

  // ---------------- clock edge detection and phases
  logic                 convPrev_reg, convPrev_next;
  logic                 track_reg,    track_next;
  logic                 hold_reg,     hold_next;
  logic                 step;
  logic                 sampleEdge;

  // a step is any change of the convert level since the last clk sample
  assign step       = convClk != convPrev_reg;
  assign sampleEdge = convClk && !convPrev_reg;

  // a phase only rises after the clock level has stood for a full cycle, so the two never overlap
  always_comb begin
    convPrev_next = convClk;
    track_next    = convClk && convPrev_reg;
    hold_next     = !convClk && !convPrev_reg;
  end

  // edge and phase registers; convPrev starts low, so a high clock at release is a sample edge
  always_ff @(posedge clk) begin
    if (rst) begin
      convPrev_reg <= 1'b0;
      track_reg    <= 1'b0;
      hold_reg     <= 1'b0;
    end else begin
      convPrev_reg <= convPrev_next;
      track_reg    <= track_next;
      hold_reg     <= hold_next;
    end
  end

  // phases leave straight from their flops
  assign trackPhase = track_reg;
  assign holdPhase  = hold_reg;

  // ---------------- alignment delay lines, stage k waits 10-k steps
  // stage k decides at step k+1; stage 10 is read straight from its input at step 11
  logic [STAGE_COUNT-1:0][STAGE_BITS-1:0] aligned;

  for (genvar k = 0; k < STAGE_COUNT; k++) begin : g_line
    localparam int DEPTH = STAGE_COUNT - 1 - k;
    if (DEPTH == 0) begin : g_direct
      assign aligned[k] = stageCodes[k];
    end else begin : g_delay
      logic [DEPTH-1:0][STAGE_BITS-1:0] line_reg, line_next;
      // each step moves the line by one slot; between steps it stands
      always_comb begin
        line_next = line_reg;
        if (step) begin
          line_next[0] = stageCodes[k];
          for (int i = 1; i < DEPTH; i++) begin
            line_next[i] = line_reg[i-1];
          end
        end
      end
      // line registers
      always_ff @(posedge clk) begin
        if (rst) begin
          line_reg <= '0;
        end else begin
          line_reg <= line_next;
        end
      end
      assign aligned[k] = line_reg[DEPTH-1];
    end
  end

  // ---------------- redundancy correction: overlapping sum of weighted partials
  // each stage carries one redundant bit, so a late decision is repaired by the next stage
  logic [STAGE_COUNT-1:0][WIDTH:0] weighted;
  logic [WIDTH:0]       corrSum;
  logic [WIDTH-1:0]     corrected;

  // stage k weighs 2^(10-k), stage 0 heaviest; neighbouring two-bit partials overlap by one bit
  for (genvar k = 0; k < STAGE_COUNT; k++) begin : g_weight
    localparam int SHIFT = STAGE_COUNT - 1 - k;
    assign weighted[k] = (WIDTH+1)'(aligned[k]) << SHIFT;
  end

  // the sum is one bit wider than the word, so overflow is seen rather than wrapped
  always_comb begin
    corrSum = '0;
    for (int k = 0; k < STAGE_COUNT; k++) begin
      corrSum = corrSum + weighted[k];
    end
    // saturate rather than roll over at positive full scale
    corrected = corrSum[WIDTH] ? WORD_FULL : corrSum[WIDTH-1:0];
  end

  // ---------------- sample tags, correction and output staging
  logic [TAG_BITS-1:0]  tag_reg,    tag_next;
  logic [WIDTH-1:0]     corr_reg,   corr_next;
  logic [WIDTH-1:0]     stage_reg,  stage_next;
  logic                 oe_reg,     oe_next;
  logic                 overrun_reg, overrun_next;
  pado_format_e         format;
  logic                 push;
  logic                 bufReady;
  pado_word_s           pushWord;
  logic [WIDTH-1:0]     coded;

  assign format = codeFormatSelect ? PADO_TWOS_COMPLEMENT : PADO_OFFSET_BINARY;

  // coding: only the top bit differs between the two formats
  always_comb begin
    case (format)
      PADO_OFFSET_BINARY:   coded = corr_reg;
      PADO_TWOS_COMPLEMENT: coded = {~corr_reg[WIDTH-1], corr_reg[WIDTH-2:0]};
      default:              coded = corr_reg;
    endcase
  end

  // a tagged sample reaches the buffer on its thirteenth step
  assign push          = step && tag_reg[TAG_BITS-1];
  assign pushWord.data = stage_reg;

  // next values of the tag line and the two word stages
  always_comb begin
    tag_next     = tag_reg;
    corr_next    = corr_reg;
    stage_next   = stage_reg;
    oe_next      = !outDisable;
    overrun_next = push && !bufReady;  // word is lost only if the buffer is still full
    if (step) begin
      tag_next = {tag_reg[TAG_BITS-2:0], sampleEdge};
      corr_next = corrected;
      stage_next = coded;
    end
  end

  // staging registers; the reset word is all zeros
  always_ff @(posedge clk) begin
    if (rst) begin
      tag_reg     <= '0;
      corr_reg    <= WORD_RESET;
      stage_reg   <= WORD_RESET;
      oe_reg      <= 1'b0;
      overrun_reg <= 1'b0;
    end else begin
      tag_reg     <= tag_next;
      corr_reg    <= corr_next;
      stage_reg   <= stage_next;
      oe_reg      <= oe_next;
      overrun_reg <= overrun_next;
    end
  end

  assign resultOe = oe_reg;
  assign overrun  = overrun_reg;

  // ---------------- two-entry buffer toward the capture side
  // the converter cannot pause, so back-pressure longer than two words shows as overrun
  pado_word_buffer #(
    .WIDTH (WIDTH)
  ) u_buffer (
    .clk      (clk),
    .rst      (rst),
    .inValid  (push),
    .inData   (pushWord.data),
    .inReady  (bufReady),
    .outValid (wordValid),
    .outData  (resultBits),
    .outReady (wordReady)
  );

endmodule

// ===== pado_output_port_props.sv
// Purpose: pin-level checks on the converter output port
// Assumes: one clock domain, synchronous active-high reset
// Notes:   latency and coding are judged by the bench
module pado_output_port_props #(
  parameter int STAGES = 11,
  parameter int WIDTH  = 12
) (
  // clock and reset
  input wire logic                  clk,
  input wire logic                  rst,
  // convert side and static pins
  input wire logic                  convClk,
  input wire pado_pkg::pado_codes_t stageCodes,
  input wire logic                  codeFormatSelect,
  input wire logic                  outDisable,
  // result side
  input wire logic [WIDTH-1:0]      resultBits,
  input wire logic                  resultOe,
  input wire logic                  wordValid,
  input wire logic                  wordReady,
  input wire logic                  trackPhase,
  input wire logic                  holdPhase,
  input wire logic                  overrun
);
  timeunit 1ns;
  timeprecision 1ps;
  import pado_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // phases never overlap and follow a settled convert level
  a_phase_exclusive: assert property (!(trackPhase && holdPhase))
    else $error("phases overlap");
  a_track_follow: assert property (convClk [*2] |=> trackPhase)
    else $error("track phase missing");
  a_hold_follow: assert property (!convClk [*2] |=> holdPhase)
    else $error("hold phase missing");
  // a gap at every convert edge keeps the switches from overlapping
  a_step_gap: assert property ($changed(convClk) |=> !trackPhase && !holdPhase)
    else $error("no phase gap at edge");
  a_oe_follow: assert property (!$past(rst) |-> resultOe == !$past(outDisable))
    else $error("enable not following pin");
  // a stalled head word stands unchanged
  a_word_stands: assert property (wordValid && !wordReady |=> wordValid && $stable(resultBits))
    else $error("head word moved");
  a_overrun_pulse: assert property (overrun |=> !overrun)
    else $error("overrun longer than a cycle");
  a_overrun_cause: assert property (overrun |-> $past(wordValid))
    else $error("overrun with empty buffer");
endmodule
bind pado_output_port pado_output_port_props #(.STAGES(STAGES), .WIDTH(WIDTH)) u_props (
  .clk(clk), .rst(rst), .convClk(convClk), .stageCodes(stageCodes),
  .codeFormatSelect(codeFormatSelect), .outDisable(outDisable), .resultBits(resultBits),
  .resultOe(resultOe), .wordValid(wordValid), .wordReady(wordReady),
  .trackPhase(trackPhase), .holdPhase(holdPhase), .overrun(overrun));

// ===== pado_capture_model.sv
// Purpose: capture logic that makes the convert clock and takes words
// Assumes: drives on the falling edge of clk
// Notes:   the convert clock stands low between runs
module pado_capture_model #(
  parameter int H = 4
) (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  run,
  input wire logic                  stall,
  input wire logic [1:0]            code,
  input wire logic                  wordValid,
  input wire logic [11:0]           resultBits,
  output logic                      convClk,
  output pado_pkg::pado_codes_t     stageCodes,
  output logic                      wordReady,
  output int                        got,
  output logic [11:0]               last
);
  timeunit 1ns;
  timeprecision 1ps;
  import pado_pkg::*;
  int   hc = 0;
  logic runD = 1'b0;
  initial convClk = 1'b0;
  initial got = 0;
  initial last = 12'h000;
  assign stageCodes = {STAGE_COUNT{code}};
  assign wordReady = !stall;
  // even duty: each level lasts H clk; a high level is always finished
  always @(negedge clk) begin
    if (rst) begin
      convClk <= 1'b0;
      hc <= 0;
    end else if (run || convClk) begin
      hc <= (hc == H - 1) ? 0 : hc + 1;
      if (hc == H - 1) convClk <= !convClk;
    end else hc <= 0;
  end
  // words before the eighth of a run predate a full pipeline
  always @(posedge clk) begin
    runD <= run;
    if (run && !runD) got <= 0;
    else if (wordValid && wordReady) begin
      got <= got + 1;
      if (got >= 7) last <= resultBits;
    end
  end
endmodule

// ===== pado_output_port_tb.sv
// Purpose: self-checking bench for the converter output port
// Assumes: inputs change on the falling edge
// Notes:   every run restarts the convert clock, so stale words are skipped
module pado_output_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pado_pkg::*;
  localparam int H = 4;
  logic clk = 0, rst = 1, run = 0, stall = 0, fmt = 0, dis = 0;
  logic [1:0] code = 2'h0;
  logic convClk, wordReady, resultOe, wordValid, trackPhase, holdPhase, overrun;
  pado_codes_t stageCodes;
  logic [WORD_BITS-1:0] resultBits, last;
  int got, miscompares = 0, n_checks = 0;
  initial forever #12.5 clk = ~clk;
  pado_output_port dut (.clk(clk), .rst(rst), .convClk(convClk), .stageCodes(stageCodes),
    .codeFormatSelect(fmt), .outDisable(dis), .resultBits(resultBits), .resultOe(resultOe),
    .wordValid(wordValid), .wordReady(wordReady), .trackPhase(trackPhase),
    .holdPhase(holdPhase), .overrun(overrun));
  pado_capture_model #(.H(H)) cap (.clk(clk), .rst(rst), .run(run), .stall(stall),
    .code(code), .wordValid(wordValid), .resultBits(resultBits), .convClk(convClk),
    .stageCodes(stageCodes), .wordReady(wordReady), .got(got), .last(last));
  task chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task end_sim;
    $display("checks %0d, miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // first word after reset: thirteen steps of H clk each, counted from the sampling edge
  task t_latency;
    int k;
    k = 0;
    code = 2'h1;
    run = 1;
    while (convClk !== 1'b1) cyc(1);
    while (wordValid !== 1'b1 && k < 200) begin
      cyc(1);
      k++;
    end
    chk(k == LATENCY_STEPS * H, "latency");
    run = 0;
    cyc(80);
  endtask
  // every code in both formats; expected word is the weighted stage sum
  task t_codes;
    int s;
    logic [WORD_BITS-1:0] e;
    for (int c = 0; c < 4; c++) begin
      for (int f = 0; f < 2; f++) begin
        code = c[1:0];
        fmt = f[0];
        run = 1;
        s = c * ((1 << STAGE_COUNT) - 1);
        e = (s > 4095) ? WORD_FULL : s[11:0];
        e[11] = e[11] ^ f[0];
        cyc(H);
        for (int i = 0; i < 400 && got < 9; i++) cyc(1);
        chk(got >= 9 && last === e, "result word");
        run = 0;
        cyc(60);
      end
    end
  endtask
  // stalled receiver: buffer fills, a word drops, the head stands
  task t_stall;
    logic [WORD_BITS-1:0] w;
    int k;
    k = 0;
    stall = 1;
    run = 1;
    while (overrun !== 1'b1 && k < 300) begin
      cyc(1);
      k++;
    end
    chk(overrun === 1'b1, "no overrun");
    w = resultBits;
    cyc(20);
    chk(wordValid === 1'b1 && resultBits === w, "head word moved");
    stall = 0;
    run = 0;
    cyc(80);
    chk(wordValid === 1'b0, "buffer not drained");
  endtask
  // disable pin is only moved while the converter is idle
  task t_disable;
    dis = 1;
    cyc(2);
    chk(resultOe === 1'b0, "outputs still driven");
    dis = 0;
    cyc(2);
    chk(resultOe === 1'b1, "outputs floating");
  endtask
  initial begin
    cyc(2);
    rst = 0;
    cyc(2);
    t_latency;
    t_disable;
    t_codes;
    t_stall;
    end_sim;
  end
  initial begin
    #(CLK_PERIOD_NS * 5000);
    miscompares++;
    end_sim;
  end
endmodule
